// ### hw/burst_addr_gen.sv
// Two-bit burst address generator, linear or interleaved order
`timescale 1ns/1ps
`default_nettype none
module burst_addr_gen (
  input  wire logic   clk_sys_i,
  input  wire logic   resetn_i,
  burst_step_if.gen   bus
);

  logic [1:0] start_reg;
  logic [1:0] start_next;
  logic [1:0] count_reg;
  logic [1:0] count_next;

  // Order of the two low bits for a given start and step count
  function automatic logic [1:0] order_bits(input logic [1:0] start, input logic [1:0] count,
                                            input logic linear);
    if (linear) begin
      order_bits = 2'(start + count); // wraps inside the aligned group [RULE_21] [RULE_23]
    end else begin
      order_bits = start ^ count;     // start XOR count: low bits of the start flipped where the count has ones [RULE_21]
    end
  endfunction : order_bits

  // Next start and count; the low bits shown are those of the access now
  always_comb begin
    start_next = start_reg;
    count_next = count_reg;
    bus.low    = order_bits(start_reg, count_reg, bus.linear);
    if (bus.load) begin
      start_next = bus.start;
      count_next = burst_sram_pkg::COUNT_RST;
      bus.low    = bus.start;
    end else if (bus.step) begin
      count_next = 2'(count_reg + burst_sram_pkg::BURST_ONE); // advance one position [RULE_12]
      bus.low    = order_bits(start_reg, count_next, bus.linear);
    end
    // No step: count held, a wait state on the same address [RULE_13]
  end

  // Start and count registers
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      start_reg <= burst_sram_pkg::START_RST;
      count_reg <= burst_sram_pkg::COUNT_RST;
    end else begin
      start_reg <= start_next;
      count_reg <= count_next;
    end
  end

endmodule : burst_addr_gen
`default_nettype wire

// ### hw/burst_sram_bus_port.sv
// Synchronous burst static memory: bus port, write control and array
//
// Operation
// RULE_01: Address inputs captured on rising clock edge
// RULE_02: All synchronous inputs registered on rising edge
// RULE_03: Each lane write enable gates byte and parity
// RULE_04: Bus drives lane enable low to write
// RULE_05: Lane writes only while byte gate asserted
// RULE_06: Global write stores the whole word
// RULE_07: Parity bits only on parity variants
// RULE_08: Primary select enables, qualifies processor strobe
// RULE_09: Selects sampled only on address loads
// RULE_10: Extra selects: one active low, one high
// RULE_11: Output enable drives data pins asynchronously
// RULE_12: Step low advances burst counter one position
// RULE_13: Step high holds address, a wait state
// RULE_14: Bus keeps step high after processor strobe
// RULE_15: Processor strobe aborts burst, loads address
// RULE_16: Processor strobe cycle always reads, needs selects
// RULE_17: Processor strobe ignored while primary select high
// RULE_18: Processor strobe, other selects off: power down
// RULE_19: Controller strobe aborts burst, loads, accesses
// RULE_20: Controller strobe, primary select high: power down
// RULE_21: Order select low linear, else interleaved
// RULE_22: Sleep keeps contents, all other inputs ignored
// RULE_23: Burst of four within aligned group
// RULE_24: Selected cycle without write enables reads
`timescale 1ns/1ps
`default_nettype none
module burst_sram_bus_port #(
  parameter int ADDR_W = burst_sram_pkg::ADDR_W_DEF,
  parameter int LANES  = burst_sram_pkg::LANES_DEF,
  parameter int PARITY = burst_sram_pkg::PARITY_DEF,
  localparam int LANE_W = burst_sram_pkg::BYTE_W + PARITY,
  localparam int WORD_W = LANES * LANE_W,
  localparam int UPPER_W = ADDR_W - burst_sram_pkg::BURST_W
) (
  input  wire logic               clk_sys_i,
  input  wire logic               resetn_i,
  input  wire logic               addr_bit0_i,
  input  wire logic               addr_bit1_i,
  input  wire logic [UPPER_W-1:0] addr_upper_i,
  input  wire logic               lane_a_write_n_i,
  input  wire logic               lane_b_write_n_i,
  input  wire logic               lane_c_write_n_i,
  input  wire logic               lane_d_write_n_i,
  input  wire logic               byte_write_gate_n_i,
  input  wire logic               all_bytes_write_n_i,
  input  wire logic               chip_sel_n_i,
  input  wire logic               chip_sel_extra_n_i,
  input  wire logic               chip_sel_high_i,
  input  wire logic               proc_addr_strobe_n_i,
  input  wire logic               ctrl_addr_strobe_n_i,
  input  wire logic               burst_step_n_i,
  input  wire logic               burst_order_i,
  input  wire logic               out_enable_n_i,
  input  wire logic               sleep_req_i,
  input  wire logic [WORD_W-1:0]  data_in_i,
  output logic      [WORD_W-1:0]  data_out_o,
  output logic                    data_oe_o,
  output logic                    power_down_o
);

  // Lane k of a word: bits [k*LANE_W +: LANE_W], parity bit on top of the byte
  // Each lane keeps its own bank, so every bank has a single writer
  logic [WORD_W-1:0] rd_word;

  burst_step_if bif ();

  burst_addr_gen u_burst (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .bus       (bif.gen)
  );

  // Synchronisers for the two asynchronous level pins
  logic [burst_sram_pkg::SYNC_STAGES-1:0] sleep_sync_reg;
  logic [burst_sram_pkg::SYNC_STAGES-1:0] sleep_sync_next;
  logic [burst_sram_pkg::SYNC_STAGES-1:0] order_sync_reg;
  logic [burst_sram_pkg::SYNC_STAGES-1:0] order_sync_next;
  logic                                   sleep_on;
  logic                                   order_high;

  // Shift the pin levels in, one stage per edge
  always_comb begin
    sleep_sync_next = {sleep_sync_reg[burst_sram_pkg::SYNC_STAGES-2:0], sleep_req_i};
    order_sync_next = {order_sync_reg[burst_sram_pkg::SYNC_STAGES-2:0], burst_order_i};
  end

  // Sleep chain resets to awake
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sleep_sync_reg <= '0;
    end else begin
      sleep_sync_reg <= sleep_sync_next;
    end
  end

  // Order chain resets high, the interleaved order of a floating pin
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      order_sync_reg <= '1;
    end else begin
      order_sync_reg <= order_sync_next;
    end
  end

  // Only the last stage is looked at; the first may be metastable
  assign sleep_on   = sleep_sync_reg[burst_sram_pkg::SYNC_STAGES-1];
  assign order_high = order_sync_reg[burst_sram_pkg::SYNC_STAGES-1];

  // All three selects agree: primary low, extra low, high-active high
  function automatic logic chips_on(input logic cs_n, input logic cs_extra_n, input logic cs_high);
    logic primary_on;
    logic extra_on;
    logic high_on;
    primary_on = !cs_n;                          // [RULE_08]
    extra_on   = !cs_extra_n;                    // [RULE_10]
    high_on    = cs_high;                        // [RULE_10]
    chips_on   = primary_on && extra_on && high_on;
  endfunction : chips_on

  // Per-lane write enables from global write, byte gate and lane enables
  function automatic logic [LANES-1:0] lane_writes(input logic gw_n, input logic bwe_n,
                                                   input logic [3:0] lane_n);
    logic [LANES-1:0] sel;
    sel = '0;
    if (!gw_n) begin
      sel = '1;                         // every lane, gate and lanes ignored [RULE_06]
    end else if (!bwe_n) begin
      sel = ~lane_n[LANES-1:0];         // lane low means write [RULE_04] [RULE_05]
    end
    // Neither asserted: a read [RULE_24]
    lane_writes = sel;
  endfunction : lane_writes

  logic [3:0] lane_n;
  assign lane_n = {lane_d_write_n_i, lane_c_write_n_i, lane_b_write_n_i, lane_a_write_n_i};

  // Port state, held upper address and power-down flag
  burst_sram_pkg::port_state_type state_reg;
  burst_sram_pkg::port_state_type state_next;
  logic [UPPER_W-1:0] upper_reg;
  logic [UPPER_W-1:0] upper_next;
  logic               down_reg;
  logic               down_next;

  // Read path: last word read and the pin drive flag
  logic [WORD_W-1:0]  rd_data_reg;
  logic [WORD_W-1:0]  rd_data_next;
  logic               drive_reg;
  logic               drive_next;

  // Per-edge cycle decode
  logic               access;
  logic               force_read;
  logic               read_cycle;
  logic [LANES-1:0]   lane_we;
  logic [ADDR_W-1:0]  acc_addr;
  logic               proc_load;
  logic               ctrl_load;

  // A processor strobe counts only with the primary select low
  assign proc_load = !proc_addr_strobe_n_i && !chip_sel_n_i; // [RULE_17] [RULE_08]
  // The controller strobe loads whatever the selects say
  assign ctrl_load = !ctrl_addr_strobe_n_i;

  // Burst generator steering
  always_comb begin
    bif.load   = 1'b0;
    bif.step   = 1'b0;
    bif.start  = {addr_bit1_i, addr_bit0_i};      // low bits caught on load [RULE_01]
    bif.linear = !order_high;                    // low selects linear order [RULE_21]
    if (!sleep_on) begin
      if (proc_load || ctrl_load) begin
        bif.load = 1'b1;                         // a new address aborts any burst [RULE_15] [RULE_19]
      end else if (state_reg == burst_sram_pkg::ST_ACTIVE) begin
        bif.step = !burst_step_n_i;              // [RULE_12] [RULE_13]
      end
    end
  end

  // Access address: fresh upper bits on a load, otherwise the held ones
  always_comb begin
    acc_addr = {upper_reg, bif.low};
    if (bif.load) begin
      acc_addr = {addr_upper_i, bif.low};        // [RULE_01]
    end
  end

  // Cycle decode: state, access kind and port outputs
  always_comb begin
    state_next   = state_reg;
    upper_next   = upper_reg;
    down_next    = down_reg;
    access       = 1'b0;
    force_read   = 1'b0;
    unique case (state_reg)
      burst_sram_pkg::ST_SLEEP,
      burst_sram_pkg::ST_DOWN,
      burst_sram_pkg::ST_ACTIVE: begin
        if (sleep_on) begin
          state_next = burst_sram_pkg::ST_SLEEP;  // everything else ignored [RULE_22]
          down_next  = 1'b1;
        end else if (proc_load) begin
          upper_next = addr_upper_i;              // [RULE_15]
          // Selects looked at only on a load, here and for the controller strobe [RULE_09]
          if (chips_on(chip_sel_n_i, chip_sel_extra_n_i, chip_sel_high_i)) begin
            state_next = burst_sram_pkg::ST_ACTIVE;
            down_next  = 1'b0;
            access     = 1'b1;
            force_read = 1'b1;                    // write controls ignored [RULE_16]
          end else begin
            state_next = burst_sram_pkg::ST_DOWN; // other selects off [RULE_18]
            down_next  = 1'b1;
          end
        end else if (ctrl_load) begin
          upper_next = addr_upper_i;              // [RULE_19]
          if (chips_on(chip_sel_n_i, chip_sel_extra_n_i, chip_sel_high_i)) begin
            state_next = burst_sram_pkg::ST_ACTIVE;
            down_next  = 1'b0;
            access     = 1'b1;                    // read or write [RULE_19]
          end else begin
            state_next = burst_sram_pkg::ST_DOWN; // primary high or others off [RULE_20]
            down_next  = 1'b1;
          end
        end else if (state_reg == burst_sram_pkg::ST_ACTIVE) begin
          access = 1'b1;                          // continue or wait, selects not looked at [RULE_09]
        end else if (state_reg == burst_sram_pkg::ST_SLEEP) begin
          // Sleep over with no load: deselected until a strobe loads
          state_next = burst_sram_pkg::ST_DOWN;
        end
      end
    endcase
  end

  // Lane writes for this edge; a processor strobe cycle never writes
  always_comb begin
    lane_we = '0;
    if (access && !force_read) begin
      lane_we = lane_writes(all_bytes_write_n_i, byte_write_gate_n_i, lane_n); // [RULE_02]
    end
  end

  // A selected cycle that writes no lane is a read
  assign read_cycle = access && (lane_we == '0); // [RULE_24]

  // Read data and drive flag; a write cycle keeps the pins released
  always_comb begin
    rd_data_next = rd_data_reg;
    drive_next   = 1'b0;
    if (read_cycle) begin
      rd_data_next = rd_word;
      drive_next   = 1'b1;                        // [RULE_24]
    end
  end

  // Control registers; power-down shows from reset
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= burst_sram_pkg::STATE_RST;
      upper_reg <= '0;
      down_reg  <= 1'b1;
    end else begin
      state_reg <= state_next;
      upper_reg <= upper_next;
      down_reg  <= down_next;
    end
  end

  // Read-path registers; pins released from reset
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_reg <= '0;
      drive_reg   <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      drive_reg   <= drive_next;
    end
  end

  // Array banks, one per lane; byte and its parity share an enable
  for (genvar k = 0; k < LANES; k++) begin : g_lane
    logic [LANE_W-1:0] bank [2**ADDR_W];

    // Self-timed write of this lane at the access address
    always_ff @(posedge clk_sys_i) begin
      if (lane_we[k]) begin
        bank[acc_addr] <= data_in_i[k*LANE_W +: LANE_W]; // [RULE_03] [RULE_07]
      end
    end

    // Flow-through read of this lane, caught by the read path
    assign rd_word[k*LANE_W +: LANE_W] = bank[acc_addr];
  end

  // Read data and power-down come straight from their registers
  assign data_out_o   = rd_data_reg;
  assign power_down_o = down_reg;

  // Output enable acts without the clock, so it bypasses any register
  assign data_oe_o    = drive_reg && !out_enable_n_i; // [RULE_11]

endmodule : burst_sram_bus_port
`default_nettype wire

// ### hw/burst_sram_pkg.sv
// Shared constants for the burst static memory front end
`default_nettype none
package burst_sram_pkg;

  // Default geometry: four byte lanes with one parity bit each
  localparam int ADDR_W_DEF   = 15;
  localparam int LANES_DEF    = 4;
  localparam int PARITY_DEF   = 1;
  localparam int BYTE_W       = 8;

  // Burst counter covers the two lowest address bits
  localparam int BURST_W      = 2;
  localparam logic [1:0] BURST_ONE = 2'h1;
  localparam logic [1:0] COUNT_RST = 2'h0;
  localparam logic [1:0] START_RST = 2'h0;

  // Port state, one-hot codes
  typedef enum logic [2:0] {
    ST_DOWN   = 3'h1,
    ST_ACTIVE = 3'h2,
    ST_SLEEP  = 3'h4
  } port_state_type;

  localparam port_state_type STATE_RST = ST_DOWN;

  // Synchroniser depth for pins from outside the clock domain
  localparam int SYNC_STAGES  = 2;

endpackage : burst_sram_pkg
`default_nettype wire

// ### hw/burst_step_if.sv
// Carrier between the port core and its burst address generator
`timescale 1ns/1ps
`default_nettype none
interface burst_step_if;
  logic       load;
  logic       step;
  logic [1:0] start;
  logic       linear;
  logic [1:0] low;

  modport core (output load, output step, output start, output linear, input low);
  modport gen  (input load, input step, input start, input linear, output low);
endinterface : burst_step_if
`default_nettype wire

// ### sim/burst_sram_bus_port_chk.sv
// Port checker: strobes, selects, power-down, sleep and output drive
`timescale 1ns/1ps
`default_nettype none
module burst_sram_bus_port_chk #(
  parameter int ADDR_W = 15,
  parameter int LANES  = 4,
  parameter int PARITY = 1
) (
  input wire logic                                           clk_sys_i,
  input wire logic                                           resetn_i,
  input wire logic                                           chip_sel_n_i,
  input wire logic                                           chip_sel_extra_n_i,
  input wire logic                                           chip_sel_high_i,
  input wire logic                                           proc_addr_strobe_n_i,
  input wire logic                                           ctrl_addr_strobe_n_i,
  input wire logic                                           all_bytes_write_n_i,
  input wire logic                                           out_enable_n_i,
  input wire logic                                           sleep_req_i,
  input wire logic [LANES*(burst_sram_pkg::BYTE_W+PARITY)-1:0] data_out_o,
  input wire logic                                           data_oe_o,
  input wire logic                                           power_down_o
);
  logic [1:0] sleep_sh_reg;
  logic [1:0] sleep_sh_next;
  logic       awake;
  logic       sel_ok;
  // Mirror of the sleep synchroniser, so loads during its latency are not judged
  always_comb sleep_sh_next = {sleep_sh_reg[0], sleep_req_i};
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) sleep_sh_reg <= 2'h0;
    else sleep_sh_reg <= sleep_sh_next;
  end
  assign awake  = !sleep_sh_reg[1];
  assign sel_ok = !chip_sel_n_i && !chip_sel_extra_n_i && chip_sel_high_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  property p_proc_read; awake && !proc_addr_strobe_n_i && sel_ok |=> data_oe_o == !out_enable_n_i; endproperty
  a_proc_read: assert property (p_proc_read) else $error("processor strobe cycle did not read");
  property p_proc_down; awake && !proc_addr_strobe_n_i && !chip_sel_n_i && !sel_ok |=> power_down_o; endproperty
  a_proc_down: assert property (p_proc_down) else $error("no power-down on bad selects");
  property p_ctrl_down; awake && !ctrl_addr_strobe_n_i && chip_sel_n_i |=> power_down_o; endproperty
  a_ctrl_down: assert property (p_ctrl_down) else $error("no power-down on deselected load");
  property p_write_quiet; awake && proc_addr_strobe_n_i && !ctrl_addr_strobe_n_i && sel_ok
    && !all_bytes_write_n_i |=> !data_oe_o; endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("pins driven on write");
  property p_load_up; awake && !ctrl_addr_strobe_n_i && sel_ok |=> !power_down_o; endproperty
  a_load_up: assert property (p_load_up) else $error("selected load left power-down");
  property p_down_stays; power_down_o && proc_addr_strobe_n_i && ctrl_addr_strobe_n_i |=> power_down_o; endproperty
  a_down_stays: assert property (p_down_stays) else $error("left power-down without load");
  property p_down_hold; power_down_o && proc_addr_strobe_n_i && ctrl_addr_strobe_n_i
    |=> $stable(data_out_o) && !data_oe_o; endproperty
  a_down_hold: assert property (p_down_hold) else $error("access while powered down");
  property p_sleep; sleep_req_i [*3] |=> power_down_o; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
  property p_oe_async; data_oe_o |-> !out_enable_n_i && !power_down_o; endproperty
  a_oe_async: assert property (p_oe_async) else $error("pins driven with output enable high");
  c_proc: cover property (awake && !proc_addr_strobe_n_i && sel_ok);
  c_write: cover property (awake && !ctrl_addr_strobe_n_i && sel_ok && !all_bytes_write_n_i);
  c_sleep: cover property (sleep_req_i [*3]);
endmodule : burst_sram_bus_port_chk
bind burst_sram_bus_port burst_sram_bus_port_chk #(.ADDR_W(ADDR_W), .LANES(LANES), .PARITY(PARITY)) chk_inst (
  .clk_sys_i, .resetn_i, .chip_sel_n_i, .chip_sel_extra_n_i, .chip_sel_high_i, .proc_addr_strobe_n_i,
  .ctrl_addr_strobe_n_i, .all_bytes_write_n_i, .out_enable_n_i, .sleep_req_i, .data_out_o, .data_oe_o,
  .power_down_o);
`default_nettype wire

// ### sim/bus_ctrl_model.sv
// Bus master model: strobes, selects, write enables, address and data
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
  input  wire logic        clk_sys_i,
  output logic      [2:0]  strb_o,
  output logic      [5:0]  wr_o,
  output logic      [4:0]  ctl_o,
  output logic      [14:0] addr_o,
  output logic      [35:0] data_o
);
  // Quiet bus until the first cycle
  initial begin
    strb_o = 3'h7;
    wr_o   = 6'h3F;
    ctl_o  = 5'h08;
    addr_o = 15'h0000;
    data_o = 36'h0;
  end
  // Change after the falling edge, hold over the sampling edge
  task automatic cyc(input logic [2:0] s, input logic [5:0] w, input logic [4:0] c,
                     input logic [14:0] a, input logic [35:0] d);
    @(negedge clk_sys_i);
    strb_o <= s;
    wr_o   <= w;  // Lane enable low asks for a write
    ctl_o  <= c;
    addr_o <= a;
    data_o <= d;
    @(posedge clk_sys_i);
  endtask : cyc
endmodule : bus_ctrl_model
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench with a reference memory model
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [31:0] SV = 32'h65536325;
  localparam logic [63:0] CV = 64'h0105010007030501;
  logic        clk_sys_i   = 1'b0;
  logic        resetn_i    = 1'b0;
  logic        burst_order = 1'b0;
  logic        oe;
  logic        pd;
  logic        ok          = 1'b0;
  logic        s1          = 1'b0;
  logic        s2          = 1'b0;
  logic [2:0]  strb;
  logic [5:0]  wr;
  logic [4:0]  ctl;
  logic [14:0] addr;
  logic [14:0] b;
  logic [14:0] up;
  logic [15:0] lfsr        = 16'h952A;
  logic [35:0] din;
  logic [35:0] dout;
  logic [35:0] mem [logic [14:0]];
  int          cnt         = 0;
  int          n_errors    = 0;
  int          n_compared  = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  bus_ctrl_model bus_ctrl_model_inst (.clk_sys_i, .strb_o(strb), .wr_o(wr), .ctl_o(ctl), .addr_o(addr), .data_o(din));
  burst_sram_bus_port burst_sram_bus_port_inst (
    .clk_sys_i, .resetn_i, .addr_bit0_i(addr[0]), .addr_bit1_i(addr[1]), .addr_upper_i(addr[14:2]),
    .lane_a_write_n_i(wr[0]), .lane_b_write_n_i(wr[1]), .lane_c_write_n_i(wr[2]), .lane_d_write_n_i(wr[3]),
    .byte_write_gate_n_i(wr[4]), .all_bytes_write_n_i(wr[5]), .chip_sel_n_i(ctl[2]),
    .chip_sel_extra_n_i(ctl[1]), .chip_sel_high_i(ctl[0]), .proc_addr_strobe_n_i(strb[2]),
    .ctrl_addr_strobe_n_i(strb[1]), .burst_step_n_i(strb[0]), .burst_order_i(burst_order),
    .out_enable_n_i(ctl[3]), .sleep_req_i(ctl[4]), .data_in_i(din), .data_out_o(dout), .data_oe_o(oe),
    .power_down_o(pd));
  // Pseudo-random source, fixed start for a repeatable run
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction : rnd
  // Selects on, output enable random
  function automatic logic [4:0] rsel();
    return 5'(rnd() & 16'h0008) | 5'h01;
  endfunction : rsel
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // One bus cycle, then the reference steps and is compared at that edge
  task automatic step(input logic [2:0] s, input logic [5:0] w, input logic [4:0] c,
                      input logic [14:0] a, input logic [35:0] d);
    logic        sy;
    logic        pr;
    logic [1:0]  lo;
    logic [14:0] ad;
    logic [35:0] m;
    bus_ctrl_model_inst.cyc(s, w, c, a, d);
    #1;
    sy = s2;
    s2 = s1;
    s1 = c[4];
    pr = !s[2] && !c[2];
    if (sy) ok = 1'b0;
    else if (pr || !s[1]) begin
      ok  = !c[2] && !c[1] && c[0];
      up  = a;
      cnt = 0;
    end else if (!s[0]) cnt++;
    lo = burst_order ? up[1:0] ^ cnt[1:0] : up[1:0] + cnt[1:0];
    ad = {up[14:2], lo};
    m  = mem.exists(ad) ? mem[ad] : 'x;
    if (ok && !pr && (!w[5] || !w[4] && w[3:0] != 4'hF)) begin
      for (int k = 0; k < 4; k++) if (!w[5] || !w[k]) m[k*9 +: 9] = d[k*9 +: 9];
      mem[ad] = m;
      check(oe, 36'h0);
    end else if (ok) begin
      check(dout, m);
      check(oe, {35'h0, !c[3]});
    end else check(oe, 36'h0);
    check(pd, {35'h0, !ok});
  endtask : step
  initial begin
    #100000;
    n_errors++;
    finish_test();
  end
  // Main sequence: bursts in both orders, byte writes, deselects, sleep
  initial begin
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    resetn_i = 1'b1;
    for (int o = 0; o < 2; o++) begin
      @(negedge clk_sys_i);
      burst_order = o[0];
      repeat (3) step(3'h5, 6'h3F, 5'h04, 15'h0000, 36'h0);
      b = 15'(rnd()) & 15'h7FFC;
      for (int i = 0; i < 4; i++) step(3'h5, 6'h1F, rsel(), b | 15'(i), {rnd(), rnd(), 4'(rnd())});
      step(3'h5, 6'h3F, rsel(), b | 15'h0002, 36'h0);
      for (int i = 0; i < 6; i++) step(i == 2 ? 3'h7 : 3'h6, 6'h3F, rsel(), ~b, ~36'h0);
    end
    for (int i = 0; i < 8; i++) begin
      step(3'h3, 6'h00, rsel(), b | 15'(i & 3), 36'h0);
      step(3'h7, {1'b1, i[0], 4'(rnd())}, rsel(), ~b, {rnd(), rnd(), 4'(rnd())});
      step(3'h5, 6'h3F, rsel(), b | 15'(i & 3), 36'h0);
    end
    for (int i = 0; i < 8; i++) step(SV[4*i +: 3], 6'h3F, CV[8*i +: 5], b, 36'h0);
    step(3'h5, 6'h3F, 5'h01, b, 36'h0);
    repeat (4) step(3'h6, 6'h1F, 5'h11, b, {rnd(), rnd(), 4'(rnd())});
    repeat (3) step(3'h7, 6'h3F, 5'h01, b, 36'h0);
    step(3'h5, 6'h3F, 5'h01, b, 36'h0);
    repeat (3) step(3'h6, 6'h3F, rsel(), b, 36'h0);
    finish_test();
  end
endmodule : tb
`default_nettype wire
